/* inc/fpc_pkg.sv */
package fpc_pkg;
    // Link timing
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned BAUD_BPS = 115200;
    localparam int unsigned BIT_CYC = CLK_HZ / BAUD_BPS;
    localparam logic [8:0] BIT_CNT = 9'(BIT_CYC - 1);
    localparam logic [8:0] HALF_CNT = 9'(BIT_CYC / 2 - 1);
    localparam logic [3:0] STOP_IDX = 4'h9;

    // Flash geometry: 4 KB in 16 blocks of 256 bytes
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DEPTH = 4096;
    localparam logic [15:0] LAST_ADDR = 16'h0fff;
    localparam logic [7:0] NUM_BLOCKS = 8'h10;
    localparam logic [7:0] ERASED = 8'hff;

    // Commands and responses
    localparam logic [7:0] CMD_COMM = 8'h01;
    localparam logic [7:0] CMD_BATCH = 8'h20;
    localparam logic [7:0] CMD_BLOCK = 8'h22;
    localparam logic [7:0] CMD_WRITE = 8'h40;
    localparam logic [7:0] CMD_SUM = 8'hb0;
    localparam logic [7:0] CMD_SEC = 8'ha0;
    localparam logic [7:0] RSP_ACK = 8'h06;
    localparam logic [7:0] RSP_NAK = 8'h15;

    // Security prohibit bits
    localparam int unsigned SEC_BLOCK = 0;
    localparam int unsigned SEC_CHIP = 1;
    localparam int unsigned SEC_WRITE = 2;
    localparam logic [2:0] SEC_RST = 3'h0;

    // Values after reset
    localparam logic [7:0] PORT_RST = 8'h00;
    localparam logic [7:0] PORT_OE_RST = 8'h00;
    localparam logic [9:0] TX_IDLE = 10'h3ff;

    typedef enum logic [6:0] {
        DS_IDLE = 7'h01,
        DS_ARG = 7'h02,
        DS_ERASE = 7'h04,
        DS_WDATA = 7'h08,
        DS_WVER = 7'h10,
        DS_SUM = 7'h20,
        DS_RESP = 7'h40
    } fpc_dev_state_t;
endpackage

/* inc/fpc_link_if.sv */
`timescale 1ns/1ps
interface fpc_link_if;
    logic onboard_mode_signal;
    logic tgt_reset_n;
    logic dev_data_o;
    logic dev_data_oe;
    logic prg_data_o;
    logic prg_data_oe;
    logic second_oscillator_pin;

    // Pulled high; any driving end pulling low wins
    assign second_oscillator_pin = !((dev_data_oe && !dev_data_o) || (prg_data_oe && !prg_data_o));

    modport device (
        input onboard_mode_signal,
        input tgt_reset_n,
        input second_oscillator_pin,
        output dev_data_o,
        output dev_data_oe
    );

    modport programmer (
        output onboard_mode_signal,
        output tgt_reset_n,
        output prg_data_o,
        output prg_data_oe,
        input second_oscillator_pin
    );
endinterface

/* hw/fpc_programmer.sv */
`timescale 1ns/1ps
module fpc_programmer (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    fpc_link_if.programmer link,
    input wire logic mode_i,
    input wire logic tgt_reset_n_i,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o
);
    logic [1:0] rxd_sync;
    logic rxd_s;
    logic mode, tgt_rst_n;
    logic tx_busy, next_tx_busy;
    logic [8:0] tx_cnt, next_tx_cnt;
    logic [3:0] tx_bit, next_tx_bit;
    logic [9:0] tx_sh, next_tx_sh;
    logic rx_busy, next_rx_busy;
    logic [8:0] rx_cnt, next_rx_cnt;
    logic [3:0] rx_bit, next_rx_bit;
    logic [7:0] rx_sh, next_rx_sh;
    logic rx_valid, next_rx_valid;

    assign rxd_s = rxd_sync[1];

    // Mode level on the first oscillator pin and the reset line that ends programming mode
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rxd_sync <= 2'h3;
            mode <= 1'h0;
            tgt_rst_n <= 1'h0;
        end else begin
            rxd_sync <= {rxd_sync[0], link.second_oscillator_pin};
            mode <= mode_i;
            tgt_rst_n <= tgt_reset_n_i;
        end
    end

    // Commands only leave this end
    always_comb begin
        next_tx_busy = tx_busy;
        next_tx_cnt = tx_cnt;
        next_tx_bit = tx_bit;
        next_tx_sh = tx_sh;
        if (!tx_busy) begin
            if (tx_valid_i) begin
                next_tx_busy = 1'h1;
                next_tx_sh = {1'h1, tx_data_i, 1'h0};
                next_tx_cnt = fpc_pkg::BIT_CNT;
                next_tx_bit = 4'h0;
            end
        end else if (tx_cnt != 9'h000) begin
            next_tx_cnt = tx_cnt - 9'h001;
        end else begin
            next_tx_cnt = fpc_pkg::BIT_CNT;
            next_tx_sh = {1'h1, tx_sh[9:1]};
            if (tx_bit == fpc_pkg::STOP_IDX) begin
                next_tx_busy = 1'h0;
            end else begin
                next_tx_bit = tx_bit + 4'h1;
            end
        end
    end

    // Own transmission is not heard back: half duplex
    always_comb begin
        next_rx_busy = rx_busy;
        next_rx_cnt = rx_cnt;
        next_rx_bit = rx_bit;
        next_rx_sh = rx_sh;
        next_rx_valid = 1'h0;
        if (!rx_busy) begin
            if (!rxd_s && !tx_busy) begin
                next_rx_busy = 1'h1;
                next_rx_cnt = fpc_pkg::HALF_CNT;
                next_rx_bit = 4'h0;
            end
        end else if (rx_cnt != 9'h000) begin
            next_rx_cnt = rx_cnt - 9'h001;
        end else begin
            next_rx_cnt = fpc_pkg::BIT_CNT;
            if (rx_bit == 4'h0 && rxd_s) begin
                next_rx_busy = 1'h0;
            end else if (rx_bit == fpc_pkg::STOP_IDX) begin
                next_rx_busy = 1'h0;
                next_rx_valid = rxd_s;
            end else begin
                if (rx_bit != 4'h0) begin
                    next_rx_sh = {rxd_s, rx_sh[7:1]};
                end
                next_rx_bit = rx_bit + 4'h1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_busy <= 1'h0;
            tx_cnt <= 9'h000;
            tx_bit <= 4'h0;
            tx_sh <= fpc_pkg::TX_IDLE;
            rx_busy <= 1'h0;
            rx_cnt <= 9'h000;
            rx_bit <= 4'h0;
            rx_sh <= 8'h00;
            rx_valid <= 1'h0;
        end else begin
            tx_busy <= next_tx_busy;
            tx_cnt <= next_tx_cnt;
            tx_bit <= next_tx_bit;
            tx_sh <= next_tx_sh;
            rx_busy <= next_rx_busy;
            rx_cnt <= next_rx_cnt;
            rx_bit <= next_rx_bit;
            rx_sh <= next_rx_sh;
            rx_valid <= next_rx_valid;
        end
    end

    assign link.onboard_mode_signal = mode;
    assign link.tgt_reset_n = tgt_rst_n;
    assign link.prg_data_o = tx_sh[0];
    assign link.prg_data_oe = tx_busy;
    assign tx_ready_o = !tx_busy;
    assign rx_valid_o = rx_valid;
    assign rx_data_o = rx_sh;
endmodule

/* hw/fpc_device.sv */
`timescale 1ns/1ps
module fpc_device (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    fpc_link_if.device link,
    input wire logic [7:0] app_port_i,
    input wire logic [7:0] app_port_oe_i,
    input wire logic [11:0] rd_addr_i,
    output logic [7:0] port_o,
    output logic [7:0] port_oe_o,
    output logic prog_mode_o,
    output logic [2:0] security_o,
    output logic [7:0] rd_data_o
);
    logic [2:0] sync0, sync1;
    logic rxd_s, mode_s, trst_n_s;
    logic [7:0] mem [0:fpc_pkg::DEPTH-1];
    logic mem_we;
    logic [11:0] mem_wa;
    logic [7:0] mem_wd;
    logic tx_go;
    logic [7:0] tx_byte;
    logic tx_busy, next_tx_busy;
    logic [8:0] tx_cnt, next_tx_cnt;
    logic [3:0] tx_bit, next_tx_bit;
    logic [9:0] tx_sh, next_tx_sh;
    logic rx_busy, next_rx_busy;
    logic [8:0] rx_cnt, next_rx_cnt;
    logic [3:0] rx_bit, next_rx_bit;
    logic [7:0] rx_sh, next_rx_sh;
    logic rx_valid, next_rx_valid;
    fpc_pkg::fpc_dev_state_t state, next_state;
    logic prog, next_prog;
    logic [7:0] cmd, next_cmd;
    logic [2:0] argc, next_argc;
    logic [31:0] args, next_args;
    logic [11:0] addr, next_addr;
    logic [11:0] last, next_last;
    logic [15:0] sum, next_sum;
    logic [7:0] wbyte, next_wbyte;
    logic fail, next_fail;
    logic [2:0] sec, next_sec;
    logic [23:0] resp, next_resp;
    logic [1:0] resp_n, next_resp_n;
    logic [7:0] next_port, next_port_oe, next_rd_data;

    assign rxd_s = sync1[0];
    assign mode_s = sync1[1];
    assign trst_n_s = sync1[2];

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync0 <= 3'h1;
            sync1 <= 3'h1;
        end else begin
            sync0 <= {link.tgt_reset_n, link.onboard_mode_signal, link.second_oscillator_pin};
            sync1 <= sync0;
        end
    end

    // Responses only leave this end
    always_comb begin
        next_tx_busy = tx_busy;
        next_tx_cnt = tx_cnt;
        next_tx_bit = tx_bit;
        next_tx_sh = tx_sh;
        if (!tx_busy) begin
            if (tx_go) begin
                next_tx_busy = 1'h1;
                next_tx_sh = {1'h1, tx_byte, 1'h0};
                next_tx_cnt = fpc_pkg::BIT_CNT;
                next_tx_bit = 4'h0;
            end
        end else if (tx_cnt != 9'h000) begin
            next_tx_cnt = tx_cnt - 9'h001;
        end else begin
            next_tx_cnt = fpc_pkg::BIT_CNT;
            next_tx_sh = {1'h1, tx_sh[9:1]};
            if (tx_bit == fpc_pkg::STOP_IDX) begin
                next_tx_busy = 1'h0;
            end else begin
                next_tx_bit = tx_bit + 4'h1;
            end
        end
    end

    // Start bit found, sample mid-bit; own transmission ignored
    always_comb begin
        next_rx_busy = rx_busy;
        next_rx_cnt = rx_cnt;
        next_rx_bit = rx_bit;
        next_rx_sh = rx_sh;
        next_rx_valid = 1'h0;
        if (!rx_busy) begin
            if (!rxd_s && !tx_busy) begin
                next_rx_busy = 1'h1;
                next_rx_cnt = fpc_pkg::HALF_CNT;
                next_rx_bit = 4'h0;
            end else if (rx_cnt != 9'h000) begin
                // Idle count times the gap before a response
                next_rx_cnt = rx_cnt - 9'h001;
            end
        end else if (rx_cnt != 9'h000) begin
            next_rx_cnt = rx_cnt - 9'h001;
        end else begin
            next_rx_cnt = fpc_pkg::BIT_CNT;
            if (rx_bit == 4'h0 && rxd_s) begin
                next_rx_busy = 1'h0;
            end else if (rx_bit == fpc_pkg::STOP_IDX) begin
                next_rx_busy = 1'h0;
                next_rx_valid = rxd_s;
            end else begin
                if (rx_bit != 4'h0) begin
                    next_rx_sh = {rxd_s, rx_sh[7:1]};
                end
                next_rx_bit = rx_bit + 4'h1;
            end
        end
    end

    always_comb begin
        logic [31:0] full;
        logic [2:0] need;
        full = {args[23:0], rx_sh};
        need = (cmd == fpc_pkg::CMD_BLOCK || cmd == fpc_pkg::CMD_SEC) ? 3'h1 : 3'h4;
        next_state = state;
        next_prog = prog;
        next_cmd = cmd;
        next_argc = argc;
        next_args = args;
        next_addr = addr;
        next_last = last;
        next_sum = sum;
        next_wbyte = wbyte;
        next_fail = fail;
        next_sec = sec;
        next_resp = resp;
        next_resp_n = resp_n;
        mem_we = 1'h0;
        mem_wa = addr;
        mem_wd = fpc_pkg::ERASED;
        tx_go = 1'h0;
        tx_byte = resp[23:16];
        case (state)
            fpc_pkg::DS_IDLE: begin
                if (rx_valid) begin
                    next_cmd = rx_sh;
                    next_argc = 3'h0;
                    next_resp = {fpc_pkg::RSP_NAK, 16'h0000};
                    next_resp_n = 2'h1;
                    if (!prog) begin
                        if (rx_sh == fpc_pkg::CMD_COMM && mode_s) begin
                            next_prog = 1'h1;
                            next_resp = {fpc_pkg::RSP_ACK, 16'h0000};
                            next_state = fpc_pkg::DS_RESP;
                        end
                    end else begin
                        next_state = fpc_pkg::DS_RESP;
                        case (rx_sh)
                            fpc_pkg::CMD_COMM: next_resp = {fpc_pkg::RSP_ACK, 16'h0000};
                            fpc_pkg::CMD_BATCH: begin
                                if (!sec[fpc_pkg::SEC_CHIP]) begin
                                    next_addr = 12'h000;
                                    next_last = fpc_pkg::LAST_ADDR[11:0];
                                    next_state = fpc_pkg::DS_ERASE;
                                end
                            end
                            fpc_pkg::CMD_BLOCK, fpc_pkg::CMD_WRITE, fpc_pkg::CMD_SUM, fpc_pkg::CMD_SEC:
                                next_state = fpc_pkg::DS_ARG;
                            default: next_state = fpc_pkg::DS_RESP;
                        endcase
                    end
                end
            end
            fpc_pkg::DS_ARG: begin
                if (rx_valid) begin
                    next_args = full;
                    next_argc = argc + 3'h1;
                    next_resp = {fpc_pkg::RSP_NAK, 16'h0000};
                    next_resp_n = 2'h1;
                    next_addr = full[27:16];
                    next_last = full[11:0];
                    next_sum = 16'h0000;
                    next_fail = 1'h0;
                    if (argc + 3'h1 == need) begin
                        next_state = fpc_pkg::DS_RESP;
                        if (cmd == fpc_pkg::CMD_SEC) begin
                            next_sec = sec | rx_sh[2:0];
                            next_resp = {fpc_pkg::RSP_ACK, 16'h0000};
                        end else if (cmd == fpc_pkg::CMD_BLOCK) begin
                            // Any of the three prohibits forbids block erase
                            if (sec == 3'h0 && rx_sh < fpc_pkg::NUM_BLOCKS) begin
                                next_addr = {rx_sh[3:0], 8'h00};
                                next_last = {rx_sh[3:0], 8'hff};
                                next_state = fpc_pkg::DS_ERASE;
                            end
                        end else if (full[31:16] <= full[15:0] && full[15:0] <= fpc_pkg::LAST_ADDR) begin
                            if (cmd == fpc_pkg::CMD_SUM) begin
                                next_state = fpc_pkg::DS_SUM;
                            end else if (!sec[fpc_pkg::SEC_WRITE]) begin
                                next_state = fpc_pkg::DS_WDATA;
                            end
                        end
                    end
                end
            end
            fpc_pkg::DS_ERASE: begin
                mem_we = 1'h1;
                next_addr = addr + 12'h001;
                if (addr == last) begin
                    if (cmd == fpc_pkg::CMD_BATCH) begin
                        // Chip prohibit survives; it also blocks reaching here
                        next_sec = sec & (3'h1 << fpc_pkg::SEC_CHIP);
                    end
                    next_resp = {fpc_pkg::RSP_ACK, 16'h0000};
                    next_resp_n = 2'h1;
                    next_state = fpc_pkg::DS_RESP;
                end
            end
            fpc_pkg::DS_WDATA: begin
                if (rx_valid) begin
                    // Programming can only clear bits, as on real flash
                    mem_we = 1'h1;
                    mem_wd = mem[addr] & rx_sh;
                    next_wbyte = rx_sh;
                    next_state = fpc_pkg::DS_WVER;
                end
            end
            fpc_pkg::DS_WVER: begin
                next_fail = fail | (mem[addr] != wbyte);
                next_addr = addr + 12'h001;
                next_state = fpc_pkg::DS_WDATA;
                if (addr == last) begin
                    next_resp = {(next_fail ? fpc_pkg::RSP_NAK : fpc_pkg::RSP_ACK), 16'h0000};
                    next_resp_n = 2'h1;
                    next_state = fpc_pkg::DS_RESP;
                end
            end
            fpc_pkg::DS_SUM: begin
                next_sum = sum + {8'h00, mem[addr]};
                next_addr = addr + 12'h001;
                if (addr == last) begin
                    next_resp = {fpc_pkg::RSP_ACK, next_sum};
                    next_resp_n = 2'h3;
                    next_state = fpc_pkg::DS_RESP;
                end
            end
            fpc_pkg::DS_RESP: begin
                // Quiet bit first: programmer may still drive its stop bit
                if (!tx_busy && !rx_busy && rx_cnt == 9'h000) begin
                    tx_go = 1'h1;
                    next_resp = {resp[15:0], 8'h00};
                    next_resp_n = resp_n - 2'h1;
                    if (resp_n == 2'h1) begin
                        next_state = fpc_pkg::DS_IDLE;
                    end
                end
            end
            default: next_state = fpc_pkg::DS_IDLE;
        endcase
        // Programmer's reset line returns to normal mode; security is kept
        if (!trst_n_s) begin
            next_state = fpc_pkg::DS_IDLE;
            next_prog = 1'h0;
            mem_we = 1'h0;
            tx_go = 1'h0;
        end
        next_port = next_prog ? fpc_pkg::PORT_RST : app_port_i;
        next_port_oe = next_prog ? fpc_pkg::PORT_OE_RST : app_port_oe_i;
        next_rd_data = mem[rd_addr_i];
    end

    always_ff @(posedge mclk_i) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_busy <= 1'h0;
            tx_cnt <= 9'h000;
            tx_bit <= 4'h0;
            tx_sh <= fpc_pkg::TX_IDLE;
            rx_busy <= 1'h0;
            rx_cnt <= 9'h000;
            rx_bit <= 4'h0;
            rx_sh <= 8'h00;
            rx_valid <= 1'h0;
            state <= fpc_pkg::DS_IDLE;
            prog <= 1'h0;
            cmd <= 8'h00;
            argc <= 3'h0;
            args <= 32'h0000_0000;
            addr <= 12'h000;
            last <= 12'h000;
            sum <= 16'h0000;
            wbyte <= 8'h00;
            fail <= 1'h0;
            sec <= fpc_pkg::SEC_RST;
            resp <= 24'h00_0000;
            resp_n <= 2'h0;
            port_o <= fpc_pkg::PORT_RST;
            port_oe_o <= fpc_pkg::PORT_OE_RST;
            rd_data_o <= 8'h00;
        end else begin
            tx_busy <= next_tx_busy;
            tx_cnt <= next_tx_cnt;
            tx_bit <= next_tx_bit;
            tx_sh <= next_tx_sh;
            rx_busy <= next_rx_busy;
            rx_cnt <= next_rx_cnt;
            rx_bit <= next_rx_bit;
            rx_sh <= next_rx_sh;
            rx_valid <= next_rx_valid;
            state <= next_state;
            prog <= next_prog;
            cmd <= next_cmd;
            argc <= next_argc;
            args <= next_args;
            addr <= next_addr;
            last <= next_last;
            sum <= next_sum;
            wbyte <= next_wbyte;
            fail <= next_fail;
            sec <= next_sec;
            resp <= next_resp;
            resp_n <= next_resp_n;
            port_o <= next_port;
            port_oe_o <= next_port_oe;
            rd_data_o <= next_rd_data;
        end
    end

    assign link.dev_data_o = tx_sh[0];
    assign link.dev_data_oe = tx_busy;
    assign prog_mode_o = prog;
    assign security_o = sec;
endmodule

/* testbench/fpc_link_props.sv */
`timescale 1ns/1ps
module fpc_link_props (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic dev_data_o,
    input wire logic dev_data_oe,
    input wire logic prg_data_o,
    input wire logic prg_data_oe,
    input wire logic second_oscillator_pin
);
    // Ten bit times per frame
    localparam int FRAME_CYC = 10 * fpc_pkg::BIT_CYC;
    logic [11:0] dev_cnt;
    logic [11:0] prg_cnt;
    logic [11:0] next_dev_cnt;
    logic [11:0] next_prg_cnt;
    always_comb begin
        next_dev_cnt = dev_data_oe ? dev_cnt + 12'h001 : 12'h000;
        next_prg_cnt = prg_data_oe ? prg_cnt + 12'h001 : 12'h000;
    end
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dev_cnt <= 12'h000;
            prg_cnt <= 12'h000;
        end else begin
            dev_cnt <= next_dev_cnt;
            prg_cnt <= next_prg_cnt;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_dev_start;
        !dev_data_o [*8];
    endsequence
    sequence s_prg_start;
        !prg_data_o [*8];
    endsequence
    property p_one_talker;
        !(dev_data_oe && prg_data_oe);
    endproperty
    property p_dev_start;
        $rose(dev_data_oe) |-> s_dev_start;
    endproperty
    property p_prg_start;
        $rose(prg_data_oe) |-> s_prg_start;
    endproperty
    property p_dev_stop;
        $fell(dev_data_oe) |-> $past(dev_data_o);
    endproperty
    property p_prg_stop;
        $fell(prg_data_oe) |-> $past(prg_data_o);
    endproperty
    property p_dev_len;
        $fell(dev_data_oe) |-> dev_cnt == FRAME_CYC;
    endproperty
    property p_prg_len;
        $fell(prg_data_oe) |-> prg_cnt == FRAME_CYC;
    endproperty
    property p_dev_bit_hold;
        dev_data_oe && $past(dev_data_oe) && $changed(dev_data_o) |=> $stable(dev_data_o) [*8];
    endproperty
    property p_wire;
        dev_data_oe && !prg_data_oe |-> second_oscillator_pin == dev_data_o;
    endproperty
    a_one_talker: assert property (p_one_talker) else $error("both ends drive the data wire");
    a_dev_start: assert property (p_dev_start) else $error("device start bit not low");
    a_prg_start: assert property (p_prg_start) else $error("programmer start bit not low");
    a_dev_stop: assert property (p_dev_stop) else $error("device stop bit not high");
    a_prg_stop: assert property (p_prg_stop) else $error("programmer stop bit not high");
    a_dev_len: assert property (p_dev_len) else $error("device frame length wrong");
    a_prg_len: assert property (p_prg_len) else $error("programmer frame length wrong");
    a_dev_bit_hold: assert property (p_dev_bit_hold) else $error("device bit too short");
    a_wire: assert property (p_wire) else $error("wire level differs from device drive");
endmodule

/* testbench/flash_programmer_command_link_bench.sv */
`timescale 1ns/1ps
module flash_programmer_command_link_bench;
    logic mclk_i, rst_n_i, mode_i, tgt_reset_n_i, tx_valid_i, tx_ready_o, rx_valid_o, prog_mode_o;
    logic [7:0] tx_data_i, rx_data_o, app_port_i, app_port_oe_i, port_o, port_oe_o, rd_data_o, d, v;
    logic [11:0] rd_addr_i;
    logic [2:0] security_o;
    logic [15:0] sum;
    logic [7:0] rxq[$];
    integer seed = 96;
    integer n_fail = 0;
    integer n_tests = 0;
    fpc_link_if link();
    fpc_device fpc_device_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(link), .app_port_i(app_port_i),
        .app_port_oe_i(app_port_oe_i), .rd_addr_i(rd_addr_i), .port_o(port_o), .port_oe_o(port_oe_o),
        .prog_mode_o(prog_mode_o), .security_o(security_o), .rd_data_o(rd_data_o));
    fpc_programmer fpc_programmer_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(link), .mode_i(mode_i),
        .tgt_reset_n_i(tgt_reset_n_i), .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i),
        .tx_ready_o(tx_ready_o), .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o));
    fpc_link_props fpc_link_props_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .dev_data_o(link.dev_data_o),
        .dev_data_oe(link.dev_data_oe), .prg_data_o(link.prg_data_o), .prg_data_oe(link.prg_data_oe),
        .second_oscillator_pin(link.second_oscillator_pin));
    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end
    // Sampled mid-cycle, away from the launching edge
    always @(negedge mclk_i) begin
        if (rx_valid_o === 1'b1) begin
            rxq.push_back(rx_data_o);
        end
    end
    task finish_test;
        $display("mismatches %0d, comparisons %0d", n_fail, n_tests);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function automatic logic [15:0] model_sum(input logic [7:0] q[$]);
        int s;
        s = 0;
        foreach (q[k]) s += q[k];
        return 16'(s);
    endfunction
    task send(input logic [7:0] b);
        int i;
        @(negedge mclk_i);
        for (i = 0; i < 5000 && tx_ready_o !== 1'b1; i++) begin
            @(negedge mclk_i);
        end
        @(posedge mclk_i);
        tx_valid_i <= 1'b1;
        tx_data_i <= b;
        @(posedge mclk_i);
        tx_valid_i <= 1'b0;
    endtask
    task xfer(input logic [7:0] c[$], input logic [7:0] e[$]);
        int i;
        rxq.delete();
        foreach (c[k]) send(c[k]);
        for (i = 0; i < 30000 && rxq.size() < e.size(); i++) begin
            @(negedge mclk_i);
        end
        check("response count", 16'(rxq.size()), 16'(e.size()));
        foreach (e[k]) check("response byte", {8'h00, rxq[k]}, {8'h00, e[k]});
        // Let the stop bit finish before the next command
        repeat (400) @(posedge mclk_i);
    endtask
    task rd(input logic [11:0] a, output logic [7:0] r);
        @(posedge mclk_i);
        rd_addr_i <= a;
        repeat (2) @(posedge mclk_i);
        @(negedge mclk_i);
        r = rd_data_o;
    endtask
    initial begin
        repeat (105000) @(posedge mclk_i);
        n_fail++;
        finish_test();
    end
    initial begin
        rst_n_i = 1'b0;
        mode_i = 1'b0;
        tgt_reset_n_i = 1'b0;
        tx_valid_i = 1'b0;
        tx_data_i = 8'h00;
        app_port_i = 8'($random(seed));
        app_port_oe_i = 8'($random(seed));
        rd_addr_i = 12'h000;
        repeat (16) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        tgt_reset_n_i <= 1'b1;
        mode_i <= 1'b1;
        repeat (8) @(posedge mclk_i);
        @(negedge mclk_i);
        check("port", {8'h00, port_o}, {8'h00, app_port_i});
        check("port oe", {8'h00, port_oe_o}, {8'h00, app_port_oe_i});
        check("mode", {15'h0000, prog_mode_o}, 16'h0000);
        xfer('{fpc_pkg::CMD_COMM}, '{fpc_pkg::RSP_ACK});
        check("mode", {15'h0000, prog_mode_o}, 16'h0001);
        check("port", {8'h00, port_o}, {8'h00, fpc_pkg::PORT_RST});
        check("port oe", {8'h00, port_oe_o}, {8'h00, fpc_pkg::PORT_OE_RST});
        xfer('{fpc_pkg::CMD_BATCH}, '{fpc_pkg::RSP_ACK});
        rd(12'($random(seed)), v);
        check("erased", {8'h00, v}, {8'h00, fpc_pkg::ERASED});
        d = 8'($random(seed));
        xfer('{fpc_pkg::CMD_WRITE, 8'h00, 8'h10, 8'h00, 8'h10, d}, '{fpc_pkg::RSP_ACK});
        rd(12'h010, v);
        check("written", {8'h00, v}, {8'h00, d});
        rd(12'h011, v);
        check("neighbour", {8'h00, v}, {8'h00, fpc_pkg::ERASED});
        sum = model_sum('{d, fpc_pkg::ERASED});
        xfer('{fpc_pkg::CMD_SUM, 8'h00, 8'h10, 8'h00, 8'h11}, '{fpc_pkg::RSP_ACK, sum[15:8], sum[7:0]});
        xfer('{fpc_pkg::CMD_SEC, 8'h01}, '{fpc_pkg::RSP_ACK});
        check("security", {13'h0000, security_o}, 16'h0001);
        xfer('{fpc_pkg::CMD_BLOCK, 8'h00}, '{fpc_pkg::RSP_NAK});
        rd(12'h010, v);
        check("kept", {8'h00, v}, {8'h00, d});
        @(posedge mclk_i);
        tgt_reset_n_i <= 1'b0;
        repeat (8) @(posedge mclk_i);
        @(negedge mclk_i);
        check("mode", {15'h0000, prog_mode_o}, 16'h0000);
        check("security", {13'h0000, security_o}, 16'h0001);
        check("port", {8'h00, port_o}, {8'h00, app_port_i});
        check("port oe", {8'h00, port_oe_o}, {8'h00, app_port_oe_i});
        finish_test();
    end
endmodule
